// *** logic/slsf_top.v ***
// Read-only status bank for receive lanes 5 and 6 of the serial link.
// Assumes all lane inputs and the read port synchronous to clk_sys.
//
// Summary of operation
// [R01] Bit 7 is 1 when disparity error count is at or above threshold.
// [R02] Bit 6 is 1 when invalid symbol count is at or above threshold.
// [R03] Bit 5 is 1 when misplaced control count is at or above threshold.
// [R04] Bit 4 is 1 when lane deskew achieved, 0 when it failed.
// [R05] Bit 3 is 1 when initial lane sync achieved, 0 when lost.
// [R06] Bit 2 is 1 when configuration checksum matches, 0 when wrong.
// [R07] Bit 1 is 1 while frame sync holds, 0 once lost.
// [R08] Bit 0 reports code group sync, even with alignment sequence skipped.
// [R09] Software ignores bits 4 to 1 while the alignment sequence is skipped.
// [R10] Lane 6 status at 0x4B6, same layout, read-only, resets to zero.
// [R11] Lane 5 status at 0x4B5, same layout, bit 7 disparity flag.
// [R12] Error flags follow counters and threshold each clock, without writes.
`timescale 1ns/100ps
`default_nettype none

`include "slsf_regs.vh"

module slsf_top #(
	parameter CNT_W = `SLSF_CNT_W
) (
	input wire clk_sys, // System clock, 100 MHz.
	input wire rst, // Asynchronous reset, active high.
	input wire [CNT_W-1:0] error_threshold, // Shared error threshold.
	input wire skip_alignment_sequence, // Alignment sequence skipped.
	input wire [CNT_W-1:0] lane5_disparity_count, // Lane 5 disparity errs.
	input wire [CNT_W-1:0] lane5_bad_symbol_count, // Lane 5 bad symbols.
	input wire [CNT_W-1:0] lane5_stray_control_count, // Lane 5 stray ctrl.
	input wire lane5_deskew_ok, // Lane 5 deskew achieved.
	input wire lane5_initial_sync_ok, // Lane 5 initial sync achieved.
	input wire lane5_config_sum_match, // Lane 5 checksum correct.
	input wire lane5_frame_lock, // Lane 5 frame sync held.
	input wire lane5_code_group_lock, // Lane 5 code group sync held.
	input wire [CNT_W-1:0] lane6_disparity_count, // Lane 6 disparity errs.
	input wire [CNT_W-1:0] lane6_bad_symbol_count, // Lane 6 bad symbols.
	input wire [CNT_W-1:0] lane6_stray_control_count, // Lane 6 stray ctrl.
	input wire lane6_deskew_ok, // Lane 6 deskew achieved.
	input wire lane6_initial_sync_ok, // Lane 6 initial sync achieved.
	input wire lane6_config_sum_match, // Lane 6 checksum correct.
	input wire lane6_frame_lock, // Lane 6 frame sync held.
	input wire lane6_code_group_lock, // Lane 6 code group sync held.
	input wire [`SLSF_ADDR_W-1:0] cfg_addr, // Configuration read address.
	input wire cfg_rd, // Read strobe, one cycle.
	output reg [`SLSF_DATA_W-1:0] cfg_rdata, // Read data.
	output reg cfg_rvalid, // Read data valid, one cycle.
	output reg cfg_rhit, // Read address belonged to this bank.
	output wire [`SLSF_DATA_W-1:0] lane5_link_status, // Lane 5 status.
	output wire [`SLSF_DATA_W-1:0] lane6_link_status, // Lane 6 status.
	output wire lane5_align_flags_valid, // Lane 5 bits 4..1 meaningful.
	output wire lane6_align_flags_valid // Lane 6 bits 4..1 meaningful.
);

	reg [`SLSF_DATA_W-1:0] cfg_rdata_next;
	reg cfg_rhit_next;

	wire [2*CNT_W-1:0] disparity_count_bus;
	wire [2*CNT_W-1:0] bad_symbol_bus;
	wire [2*CNT_W-1:0] stray_control_bus;
	wire [1:0] deskew_ok_bus;
	wire [1:0] initial_sync_bus;
	wire [1:0] config_sum_bus;
	wire [1:0] frame_lock_bus;
	wire [1:0] code_group_bus;
	wire [2*`SLSF_DATA_W-1:0] status_bus;

	// Lane inputs gathered into buses, lane 5 in the low slice, so both
	// lanes come from one loop and cannot drift apart in their wiring.
	assign disparity_count_bus = {lane6_disparity_count, lane5_disparity_count};
	assign bad_symbol_bus = {lane6_bad_symbol_count, lane5_bad_symbol_count};
	assign stray_control_bus = {lane6_stray_control_count,
		lane5_stray_control_count};
	assign deskew_ok_bus = {lane6_deskew_ok, lane5_deskew_ok};
	assign initial_sync_bus = {lane6_initial_sync_ok, lane5_initial_sync_ok};
	assign config_sum_bus = {lane6_config_sum_match, lane5_config_sum_match};
	assign frame_lock_bus = {lane6_frame_lock, lane5_frame_lock};
	assign code_group_bus = {lane6_code_group_lock, lane5_code_group_lock};

	// Status registers split back out to the per-lane ports.
	assign lane5_link_status = status_bus[`SLSF_DATA_W-1:0]; // [R11]
	assign lane6_link_status = status_bus[2*`SLSF_DATA_W-1:`SLSF_DATA_W]; // [R10]

	// One flag register per lane.
	genvar lane_idx;
	generate
		for (lane_idx = 0; lane_idx < 2; lane_idx = lane_idx + 1) begin : g_lane
			slsf_lane #(
				.CNT_W(CNT_W)
			) u_lane (
				.clk_sys(clk_sys),
				.rst(rst),
				.error_threshold(error_threshold),
				.disparity_err_count(disparity_count_bus[lane_idx*CNT_W +: CNT_W]),
				.bad_symbol_count(bad_symbol_bus[lane_idx*CNT_W +: CNT_W]),
				.stray_control_count(stray_control_bus[lane_idx*CNT_W +: CNT_W]),
				.deskew_ok(deskew_ok_bus[lane_idx]),
				.initial_sync_ok(initial_sync_bus[lane_idx]),
				.config_sum_match(config_sum_bus[lane_idx]),
				.frame_lock(frame_lock_bus[lane_idx]),
				.code_group_lock(code_group_bus[lane_idx]),
				.status_reg(status_bus[lane_idx*`SLSF_DATA_W +: `SLSF_DATA_W])
			);
		end
	endgenerate

	// The alignment results carry no meaning with the sequence skipped;
	// the bits are still reported raw and software must mask them.
	assign lane5_align_flags_valid = ~skip_alignment_sequence; // [R09]
	assign lane6_align_flags_valid = ~skip_alignment_sequence; // [R09]

	// Address decode. Writes do not exist on this port, so the bank is
	// read-only by construction; unmapped addresses read as zero.
	always @* begin
		cfg_rdata_next = `SLSF_UNMAPPED_DATA;
		cfg_rhit_next = 1'b0;
		case (cfg_addr)
			`SLSF_LANE5_STATUS_ADDR: begin
				cfg_rdata_next = lane5_link_status; // [R11]
				cfg_rhit_next = 1'b1;
			end
			`SLSF_LANE6_STATUS_ADDR: begin
				cfg_rdata_next = lane6_link_status; // [R10]
				cfg_rhit_next = 1'b1;
			end
			default: begin
				cfg_rdata_next = `SLSF_UNMAPPED_DATA;
				cfg_rhit_next = 1'b0;
			end
		endcase
	end

	// Read answer one cycle after the strobe; data holds until next read.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_rdata <= `SLSF_STATUS_RESET;
			cfg_rvalid <= 1'b0;
			cfg_rhit <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= cfg_rdata_next;
				cfg_rhit <= cfg_rhit_next;
			end
		end
	end

endmodule

`default_nettype wire

// *** logic/slsf_regs.vh ***
// Register map and field layout of the serial lane status flag bank.
// Included by the lane flag module and by the top of the bank.
`ifndef SLSF_REGS_VH
`define SLSF_REGS_VH

// Width of the configuration port address and of a status register.
`define SLSF_ADDR_W 12
`define SLSF_DATA_W 8

// Addresses of the two lane status registers.
`define SLSF_LANE5_STATUS_ADDR 12'h4B5
`define SLSF_LANE6_STATUS_ADDR 12'h4B6

// Field positions inside every lane status register.
`define SLSF_BIT_DISPARITY_ERR 7
`define SLSF_BIT_BAD_SYMBOL 6
`define SLSF_BIT_STRAY_CONTROL 5
`define SLSF_BIT_DESKEW_OK 4
`define SLSF_BIT_INITIAL_SYNC_OK 3
`define SLSF_BIT_CONFIG_SUM_MATCH 2
`define SLSF_BIT_FRAME_LOCK 1
`define SLSF_BIT_CODE_GROUP_LOCK 0

// Reset value of every lane status register.
`define SLSF_STATUS_RESET 8'h00

// Value returned for an address that holds no register of this bank.
`define SLSF_UNMAPPED_DATA 8'h00

// Width of the error counters and of the shared error threshold.
`define SLSF_CNT_W 8

`endif

// *** logic/slsf_lane.v ***
// Status flags of one receive lane, packed into one eight-bit register.
// Assumes error counters and alignment results synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none

`include "slsf_regs.vh"

module slsf_lane #(
	parameter CNT_W = `SLSF_CNT_W
) (
	input wire clk_sys, // System clock.
	input wire rst, // Asynchronous reset, active high.
	input wire [CNT_W-1:0] error_threshold, // Shared error threshold.
	input wire [CNT_W-1:0] disparity_err_count, // Disparity error count.
	input wire [CNT_W-1:0] bad_symbol_count, // Invalid symbol count.
	input wire [CNT_W-1:0] stray_control_count, // Misplaced control count.
	input wire deskew_ok, // Lane deskew achieved.
	input wire initial_sync_ok, // Initial lane sync achieved.
	input wire config_sum_match, // Configuration checksum correct.
	input wire frame_lock, // Frame sync held.
	input wire code_group_lock, // Code group sync held.
	output reg [`SLSF_DATA_W-1:0] status_reg // Packed lane status.
);

	wire disparity_err_flag;
	wire bad_symbol_flag;
	wire stray_control_flag;
	reg [`SLSF_DATA_W-1:0] status_next;

	// Threshold compares; "at or above" so a count equal to the
	// threshold already raises the flag.
	assign disparity_err_flag = (disparity_err_count >= error_threshold); // [R01] [R12]
	assign bad_symbol_flag = (bad_symbol_count >= error_threshold); // [R02] [R12]
	assign stray_control_flag = (stray_control_count >= error_threshold); // [R03] [R12]

	// Pack the eight flags in their fixed bit positions.
	always @* begin
		status_next = `SLSF_STATUS_RESET;
		status_next[`SLSF_BIT_DISPARITY_ERR] = disparity_err_flag; // [R01]
		status_next[`SLSF_BIT_BAD_SYMBOL] = bad_symbol_flag; // [R02]
		status_next[`SLSF_BIT_STRAY_CONTROL] = stray_control_flag; // [R03]
		status_next[`SLSF_BIT_DESKEW_OK] = deskew_ok; // [R04]
		status_next[`SLSF_BIT_INITIAL_SYNC_OK] = initial_sync_ok; // [R05]
		status_next[`SLSF_BIT_CONFIG_SUM_MATCH] = config_sum_match; // [R06]
		status_next[`SLSF_BIT_FRAME_LOCK] = frame_lock; // [R07]
		// Code group lock is passed through even with the alignment
		// sequence skipped, since it does not depend on it.
		status_next[`SLSF_BIT_CODE_GROUP_LOCK] = code_group_lock; // [R08]
	end

	// One register stage keeps the long compare paths off the read mux.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			status_reg <= `SLSF_STATUS_RESET; // [R10]
		end else begin
			status_reg <= status_next; // [R12]
		end
	end

endmodule

`default_nettype wire

// *** tb/slsf_xmit_model.sv ***
// Far-end transmitter model of one lane: error counters and lock levels.
// Assumes the bench moves err_en and locks just after a clk_sys edge.
`timescale 1ns/100ps
`default_nettype none
module slsf_xmit_model (
	input wire logic clk_sys, // Receiver clock.
	input wire logic rst, // Reset, active high.
	input wire logic [2:0] err_en, // Count enables: stray, symbol, disparity.
	input wire logic [4:0] locks, // Deskew, init, sum, frame, code group.
	output logic [2:0][7:0] cnt, // Error counts seen by the receiver.
	output logic [4:0] lock_out // Lock results as levels.
);
	// Counts saturate, so a long burst never wraps back under the threshold.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) cnt <= '0;
		else for (int i = 0; i < 3; i++)
			if (err_en[i] && cnt[i] != 8'hFF) cnt[i] <= cnt[i] + 8'h01;
	end
	assign lock_out = locks; // Results are held levels, not pulses.
endmodule
`default_nettype wire

// *** tb/slsf_properties.sv ***
// Checker of the lane status bank, bound to the bank's top module.
// Assumes one clock domain; status lags its inputs by one edge.
`timescale 1ns/100ps
`default_nettype none
module slsf_props #(parameter CNT_W = 8) (
	input wire logic clk_sys, rst, skip_alignment_sequence, cfg_rd,
	input wire logic cfg_rvalid, cfg_rhit, lane5_align_flags_valid,
	input wire logic lane5_deskew_ok, lane5_code_group_lock,
	input wire logic [CNT_W-1:0] error_threshold, lane5_disparity_count,
	input wire logic [CNT_W-1:0] lane5_bad_symbol_count,
	input wire logic [CNT_W-1:0] lane5_stray_control_count,
	input wire logic [11:0] cfg_addr,
	input wire logic [7:0] cfg_rdata, lane5_link_status, lane6_link_status
);
	// The first edge after reset still shows the cleared value, so skip it.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_disp_flag: assert property (!$past(rst) |->
		lane5_link_status[7] == ($past(lane5_disparity_count) >=
		$past(error_threshold))) else $error("bit 7 wrong");
	chk_symbol_flag: assert property (!$past(rst) |->
		lane5_link_status[6] == ($past(lane5_bad_symbol_count) >=
		$past(error_threshold))) else $error("bit 6 wrong");
	chk_stray_flag: assert property (!$past(rst) |->
		lane5_link_status[5] == ($past(lane5_stray_control_count) >=
		$past(error_threshold))) else $error("bit 5 wrong");
	chk_deskew_bit: assert property (!$past(rst) |->
		lane5_link_status[4] == $past(lane5_deskew_ok)) else $error("bit 4");
	chk_cg_lock: assert property (!$past(rst) |->
		lane5_link_status[0] == $past(lane5_code_group_lock)) else $error("b0");
	chk_align_valid: assert property (lane5_align_flags_valid ==
		!skip_alignment_sequence) else $error("align valid wrong");
	chk_read_lane6: assert property (cfg_rd && cfg_addr == 12'h4B6 |=>
		cfg_rvalid && cfg_rhit && cfg_rdata == $past(lane6_link_status))
		else $error("lane 6 read wrong");
	chk_read_lane5: assert property (cfg_rd && cfg_addr == 12'h4B5 |=>
		cfg_rvalid && cfg_rhit && cfg_rdata == $past(lane5_link_status))
		else $error("lane 5 read wrong");
endmodule
`default_nettype wire

// *** tb/serial_lane_status_flags_tb.sv ***
// Bench of the lane status bank: reset, lock bits, thresholds, reads.
// Assumes one far-end model per lane and clk_sys at 100 MHz.
`timescale 1ns/100ps
`default_nettype none
module serial_lane_status_flags_tb;
	logic clk_sys = 0, rst = 1, skip = 0, rd = 0, rvalid, rhit, v5, v6;
	logic [7:0] thr = 8'hFF, rdata, s5, s6;
	logic [11:0] addr = 12'h000;
	logic [2:0] en5 = 0, en6 = 0;
	logic [4:0] lk5 = 0, lk6 = 0, lo5, lo6;
	logic [2:0][7:0] c5, c6;
	int n_mismatch = 0, checks = 0;
	slsf_xmit_model m5 (.clk_sys, .rst, .err_en(en5), .locks(lk5),
		.cnt(c5), .lock_out(lo5));
	slsf_xmit_model m6 (.clk_sys, .rst, .err_en(en6), .locks(lk6),
		.cnt(c6), .lock_out(lo6));
	slsf_top uut (.clk_sys, .rst, .error_threshold(thr),
		.skip_alignment_sequence(skip), .lane5_disparity_count(c5[0]),
		.lane5_bad_symbol_count(c5[1]), .lane5_stray_control_count(c5[2]),
		.lane5_deskew_ok(lo5[4]), .lane5_initial_sync_ok(lo5[3]),
		.lane5_config_sum_match(lo5[2]), .lane5_frame_lock(lo5[1]),
		.lane5_code_group_lock(lo5[0]), .lane6_disparity_count(c6[0]),
		.lane6_bad_symbol_count(c6[1]), .lane6_stray_control_count(c6[2]),
		.lane6_deskew_ok(lo6[4]), .lane6_initial_sync_ok(lo6[3]),
		.lane6_config_sum_match(lo6[2]), .lane6_frame_lock(lo6[1]),
		.lane6_code_group_lock(lo6[0]), .cfg_addr(addr), .cfg_rd(rd),
		.cfg_rdata(rdata), .cfg_rvalid(rvalid), .cfg_rhit(rhit),
		.lane5_link_status(s5), .lane6_link_status(s6),
		.lane5_align_flags_valid(v5), .lane6_align_flags_valid(v6));
	// Clock of 10 ns, and a watchdog far beyond the 40 or so cycles used.
	initial forever #5 clk_sys = ~clk_sys;
	initial begin
		#20000 n_mismatch++;
		tally_and_finish();
	end
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// One read; the strobe is dropped after the taking edge, then judged.
	task automatic rd_chk(logic [11:0] a, logic [7:0] exp, logic hit);
		@(posedge clk_sys) #1 addr = a;
		rd = 1;
		cyc(1);
		rd = 0;
		chk("read", {rvalid, rhit, rdata}, {1'b1, hit, exp});
	endtask
	task automatic t_locks;
		for (int i = 0; i < 5; i++) begin
			lk5 = 5'h01 << i;
			lk6 = ~lk5;
			cyc(1);
			chk("lane5", s5, {3'b000, lk5});
			chk("lane6", s6, {3'b000, lk6});
		end
		rd_chk(12'h4B6, {3'b000, lk6}, 1);
		skip = 1;
		lk5 = 5'h01;
		cyc(1);
		chk("lane5 skip", s5, 8'h01);
		chk("valid", {v5, v6}, 2'b00);
	endtask
	// Disparity 5 and stray 6 stop at 4, symbol 6 at 3; thresholds 4 then 3.
	task automatic t_thr;
		en5 = 3'b001;
		en6 = 3'b110;
		cyc(3);
		en6 = 3'b100;
		cyc(1);
		en5 = 0;
		en6 = 0;
		for (int t = 4; t > 2; t--) begin
			thr = t;
			cyc(1);
			chk("disp5", s5[7], 4 >= t);
			chk("sym6", s6[6], 3 >= t);
			chk("stray6", s6[5], 4 >= t);
		end
		rd_chk(12'h4B5, 8'h81, 1);
		rd_chk(12'h4B7, 8'h00, 0);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(20);
		chk("reset", {s5, s6}, 16'h0000);
		rst = 0;
		rd_chk(12'h4B5, 8'h00, 1);
		t_locks();
		t_thr();
		tally_and_finish();
	end
endmodule
bind slsf_top slsf_props #(.CNT_W(CNT_W)) chk (.*);
`default_nettype wire
